// ===== pkg/dtxc_pkg.sv
// Package for the discontinuous transmission control block
package dtxc_pkg;
  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] DTXC_REG_CTRL = 8'h00;
  localparam logic [7:0] DTXC_REG_STATUS = 8'h04;
  localparam logic [7:0] DTXC_REG_SCHED = 8'h08;
  // Control field positions
  localparam int DTXC_CTRL_DL_IND = 0;
  localparam int DTXC_CTRL_UL_IND = 1;
  localparam int DTXC_CTRL_C0 = 2;
  localparam int DTXC_CTRL_FILL = 3;
  localparam int DTXC_CTRL_MODE_LSB = 4;
  localparam int DTXC_CTRL_LOAD = 8;
  localparam logic [31:0] DTXC_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] DTXC_SCHED_RESET = 32'h0000_0001;
  // Silence descriptor field value in uplink silence frames
  localparam logic [1:0] DTXC_SID_SILENCE = 2'h3;
  localparam logic [1:0] DTXC_SID_SPEECH = 2'h0;
  localparam logic [1:0] DTXC_SID_VALID = 2'h2;
  // All E1 bits of a radio link frame set
  localparam logic [3:0] DTXC_E1_ALL = 4'hf;
  localparam int DTXC_E1_WIDTH = 4;
  // Channel modes
  typedef enum logic [3:0] {
    DTXC_MODE_SIGNAL = 4'h0,
    DTXC_MODE_FS1_UNI = 4'h1,
    DTXC_MODE_FS2_UNI = 4'h2,
    DTXC_MODE_FS1_BI = 4'h3,
    DTXC_MODE_FS2_BI = 4'h4,
    DTXC_MODE_HS = 4'h5,
    DTXC_MODE_NT144_UNI = 4'h6,
    DTXC_MODE_NT96_UNI = 4'h7,
    DTXC_MODE_NT48_HR = 4'h8,
    DTXC_MODE_NT144_BI = 4'h9,
    DTXC_MODE_NT96_BI = 4'ha,
    DTXC_MODE_NT48_FR = 4'hb,
    DTXC_MODE_TRANSP = 4'hc
  } dtxc_mode_t;
  // Downlink silence state, Gray order
  typedef enum logic [1:0] {
    DTXC_ST_ACTIVE = 2'b00,
    DTXC_ST_SPEECH_SIL = 2'b01,
    DTXC_ST_DATA_IDLE = 2'b11
  } dtxc_state_t;
endpackage : dtxc_pkg

// ===== src/dtxc_top.sv
// Discontinuous transmission control: downlink gating and uplink marking
// Notes on behaviour
// R1 - Downlink gating enabled by activation or mode modify with indicator set
// R2 - Downlink gating applies to speech and 14.4/9.6 data; 4.8 data half rate only
// R3 - Other channel modes ignore the downlink indicator, transmit continuously
// R4 - Speech gating begins on a downlink frame carrying comfort noise
// R5 - Data gating begins on complete radio link frame with all E1 bits one
// R6 - Downlink gating on/off flag carried in frames to the transcoder
// R7 - Each downlink speech frame's descriptor code word decides speech or noise
// R8 - Descriptor frames at standard positions; stolen ones use alternative positions
// R9 - Transmitter off in silence except descriptor, signalling, C0, fill dummy bursts
// R10 - Idle detection frames are checked on E1 bits and not transmitted while downlink gating is active
// R11 - Idle data sends layer 2 fill frame on signalling in descriptor positions
// R12 - Transmitter off during idle data with the same exceptions as speech
// R13 - Uplink indicator ignored; uplink handling always ready
// R14 - Uplink handling for full rate both codecs and half rate speech
// R15 - Uplink data frames forwarded unchanged
// R16 - Each uplink speech frame gets comfort noise flag from its code word
// R17 - Uplink silence, full rate codec one: descriptor field set to three
// R18 - Uplink silence, full rate codec two: bad frame indicator set
// R19 - Uplink silence, half rate: bad frame indicator set
// R20 - Transmit gate decided per burst before burst start
module dtxc_top
  import dtxc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // Downlink frames from the transcoder
  input wire logic i_dl_frame_valid,
  input wire logic i_dl_frame_is_data,
  input wire logic [1:0] i_dl_sid_code,
  input wire logic [3:0] i_dl_e1_bits,
  // Burst schedule from TDMA timing
  input wire logic i_burst_pre,
  input wire logic i_sid_position,
  input wire logic i_alt_sid_position,
  input wire logic i_sid_stolen,
  input wire logic i_facch_pending,
  // Downlink outputs
  output logic o_tx_gate,
  output logic o_tx_frame_drop,
  output logic o_send_fill_frame,
  output logic o_send_sid_frame,
  output logic o_downlink_silence_gating_indicator,
  // Uplink frames from the mobile
  input wire logic i_ul_frame_valid,
  input wire logic i_ul_frame_is_speech,
  input wire logic [1:0] i_ul_sid_code,
  input wire logic i_ul_bfi,
  output logic o_ul_frame_valid,
  output logic o_ul_comfort_noise,
  output logic [1:0] o_ul_sid_field,
  output logic o_ul_bfi
);

  // Registers
  logic [31:0] ctrl;
  logic [31:0] sched;
  logic dl_enabled;
  dtxc_mode_t mode;
  dtxc_state_t state;
  dtxc_state_t next_state;
  logic ul_silence;
  logic [31:0] next_rd;

  // Downlink gating is possible only in the supported mode set
  function automatic logic dtxc_dl_capable(input dtxc_mode_t m);
    dtxc_dl_capable = (m == DTXC_MODE_FS1_UNI) || (m == DTXC_MODE_FS2_UNI) ||
                      (m == DTXC_MODE_FS1_BI) || (m == DTXC_MODE_FS2_BI) ||
                      (m == DTXC_MODE_HS) || (m == DTXC_MODE_NT144_UNI) ||
                      (m == DTXC_MODE_NT96_UNI) || (m == DTXC_MODE_NT48_HR) ||
                      (m == DTXC_MODE_NT144_BI) || (m == DTXC_MODE_NT96_BI);
  endfunction

  // Modes whose uplink frames are speech
  function automatic logic dtxc_is_speech(input dtxc_mode_t m);
    dtxc_is_speech = (m == DTXC_MODE_FS1_UNI) || (m == DTXC_MODE_FS2_UNI) ||
                     (m == DTXC_MODE_FS1_BI) || (m == DTXC_MODE_FS2_BI) ||
                     (m == DTXC_MODE_HS);
  endfunction

  // Bus decode; writes land at the edge where the master sees ack
  wire bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire bus_done = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we;
  wire wr_ctrl = bus_done && (i_wb_adr == DTXC_REG_CTRL) && i_wb_sel[0];
  wire wr_sched = bus_done && (i_wb_adr == DTXC_REG_SCHED) && i_wb_sel[0];
  wire load_msg = wr_ctrl && i_wb_dat[DTXC_CTRL_LOAD];
  wire [3:0] msg_mode = i_wb_dat[DTXC_CTRL_MODE_LSB +: 4];

  // Downlink frame classification
  wire active_dl = dl_enabled && dtxc_dl_capable(mode);
  wire dl_noise = i_dl_frame_valid && !i_dl_frame_is_data &&
                  (i_dl_sid_code == DTXC_SID_VALID);
  wire dl_speech = i_dl_frame_valid && !i_dl_frame_is_data && !dl_noise;
  wire dl_idle = i_dl_frame_valid && i_dl_frame_is_data &&
                 (i_dl_e1_bits == DTXC_E1_ALL);
  wire dl_busy = i_dl_frame_valid && i_dl_frame_is_data && !dl_idle;
  wire silent = (state != DTXC_ST_ACTIVE);
  // Stolen descriptor frames move to the alternative positions
  wire sid_slot = i_sid_stolen ? i_alt_sid_position : i_sid_position;
  // A slot sends only if permitted, so a sent frame never meets a dark transmitter
  wire sid_due = sid_slot && sched[0];
  wire keep_on = !silent || sid_due || i_facch_pending ||
                 ctrl[DTXC_CTRL_C0] || ctrl[DTXC_CTRL_FILL];

  // Uplink classification
  wire ul_speech = i_ul_frame_is_speech && dtxc_is_speech(mode);
  wire ul_noise = ul_speech && (i_ul_sid_code == DTXC_SID_VALID);
  wire ul_fs1 = (mode == DTXC_MODE_FS1_UNI) || (mode == DTXC_MODE_FS1_BI);

  // Read mux
  always_comb begin
    next_rd = 32'h0000_0000;
    case (i_wb_adr)
      DTXC_REG_CTRL: next_rd = ctrl;
      DTXC_REG_STATUS: next_rd = {26'h0, ul_silence, o_tx_gate, active_dl,
                                  dl_enabled, state};
      DTXC_REG_SCHED: next_rd = sched;
      default: next_rd = 32'h0000_0000;
    endcase
  end

  // Wishbone: one registered ack per request, a cycle after the strobe; unmapped reads as zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_req) begin
        o_wb_dat <= next_rd;
      end
    end
  end

  // Control registers; the uplink indicator bit is stored but never used
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= DTXC_CTRL_RESET;
      sched <= DTXC_SCHED_RESET;
      dl_enabled <= 1'b0;
      mode <= DTXC_MODE_SIGNAL;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {23'h0, 1'b0, i_wb_dat[7:0]};
      end
      if (wr_sched) begin
        sched <= i_wb_dat;
      end
      if (load_msg) begin
        mode <= dtxc_mode_t'(msg_mode);
        dl_enabled <= i_wb_dat[DTXC_CTRL_DL_IND]; // [R1] [R13]
      end
    end
  end

  // Downlink silence state
  always_comb begin
    next_state = state;
    case (state)
      DTXC_ST_ACTIVE: begin
        if (!active_dl) begin
          next_state = DTXC_ST_ACTIVE; // [R3]
        end else if (dl_noise) begin
          next_state = DTXC_ST_SPEECH_SIL; // [R4] [R7]
        end else if (dl_idle) begin
          next_state = DTXC_ST_DATA_IDLE; // [R5] [R2]
        end
      end
      DTXC_ST_SPEECH_SIL: begin
        if (!active_dl || dl_speech) begin
          next_state = DTXC_ST_ACTIVE;
        end
      end
      DTXC_ST_DATA_IDLE: begin
        if (!active_dl || dl_busy) begin
          next_state = DTXC_ST_ACTIVE;
        end
      end
      default: next_state = DTXC_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= DTXC_ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // Per burst decisions taken at the burst lead-in strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_gate <= 1'b1;
      o_send_fill_frame <= 1'b0;
      o_send_sid_frame <= 1'b0;
    end else if (i_burst_pre) begin
      o_tx_gate <= keep_on; // [R20] [R9] [R12]
      o_send_sid_frame <= (state == DTXC_ST_SPEECH_SIL) && sid_due; // [R8]
      o_send_fill_frame <= (state == DTXC_ST_DATA_IDLE) && sid_due; // [R11]
    end
  end

  // Idle detection frames are dropped while downlink gating is active; flag reported to the transcoder
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_frame_drop <= 1'b0;
      o_downlink_silence_gating_indicator <= 1'b0;
    end else begin
      o_tx_frame_drop <= dl_idle && active_dl; // [R10]
      o_downlink_silence_gating_indicator <= active_dl; // [R6]
    end
  end

  // Uplink marking; data passes unchanged
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ul_frame_valid <= 1'b0;
      o_ul_comfort_noise <= 1'b0;
      o_ul_sid_field <= DTXC_SID_SPEECH;
      o_ul_bfi <= 1'b0;
      ul_silence <= 1'b0;
    end else begin
      o_ul_frame_valid <= i_ul_frame_valid;
      if (i_ul_frame_valid) begin
        o_ul_comfort_noise <= ul_noise; // [R16] [R14]
        o_ul_sid_field <= i_ul_sid_code; // [R15]
        o_ul_bfi <= i_ul_bfi;
        if (ul_speech) begin
          ul_silence <= ul_noise;
        end
        if (ul_speech && ul_silence && !ul_noise) begin
          // Silence filler frame after noise
          if (ul_fs1) begin
            o_ul_sid_field <= DTXC_SID_SILENCE; // [R17]
          end else begin
            o_ul_bfi <= 1'b1; // [R18] [R19]
          end
        end
      end
    end
  end

  // Gate follows the silence state at each burst decision
  property p_gate_on_active;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_burst_pre && !silent) |=> o_tx_gate;
  endproperty
  a_gate_on_active: assert property (p_gate_on_active) else $error("gate off while active"); // [R9]

  property p_gate_off_silent;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_burst_pre && silent && !sid_slot && !i_facch_pending && !ctrl[DTXC_CTRL_C0]
       && !ctrl[DTXC_CTRL_FILL]) |=> !o_tx_gate;
  endproperty
  a_gate_off_silent: assert property (p_gate_off_silent) else $error("gate on in silence"); // [R12]

  property p_unsupported;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !dtxc_dl_capable(mode) |=> (state == DTXC_ST_ACTIVE);
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("silence in bad mode"); // [R3]

  property p_noise_enters;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (state == DTXC_ST_ACTIVE && active_dl && dl_noise) |=> (state == DTXC_ST_SPEECH_SIL);
  endproperty
  a_noise_enters: assert property (p_noise_enters) else $error("noise missed"); // [R4]

  property p_idle_enters;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (state == DTXC_ST_ACTIVE && active_dl && dl_idle) |=> (state == DTXC_ST_DATA_IDLE);
  endproperty
  a_idle_enters: assert property (p_idle_enters) else $error("idle missed"); // [R5]

  property p_drop;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (dl_idle && active_dl) |=> o_tx_frame_drop;
  endproperty
  a_drop: assert property (p_drop) else $error("idle frame not dropped"); // [R10]

  property p_flag;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      ##1 (o_downlink_silence_gating_indicator == $past(active_dl));
  endproperty
  a_flag: assert property (p_flag) else $error("flag mismatch"); // [R6]

  property p_ul_noise;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ul_frame_valid && ul_noise) |=> (o_ul_frame_valid && o_ul_comfort_noise);
  endproperty
  a_ul_noise: assert property (p_ul_noise) else $error("noise flag missing"); // [R16]

  property p_ul_data;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ul_frame_valid && !ul_speech) |=> (o_ul_bfi == $past(i_ul_bfi));
  endproperty
  a_ul_data: assert property (p_ul_data) else $error("data altered"); // [R15]

  property p_fill;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_burst_pre && state == DTXC_ST_DATA_IDLE && sid_due) |=> o_send_fill_frame;
  endproperty
  a_fill: assert property (p_fill) else $error("fill frame missing"); // [R11]

  // Descriptor frame goes out with the transmitter on
  property p_sid_frame;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_burst_pre && state == DTXC_ST_SPEECH_SIL && sid_due) |=>
      (o_send_sid_frame && o_tx_gate);
  endproperty
  a_sid_frame: assert property (p_sid_frame) else $error("descriptor frame missing"); // [R8]

  property p_quiet_active;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_burst_pre && state == DTXC_ST_ACTIVE) |=> (!o_send_sid_frame && !o_send_fill_frame);
  endproperty
  a_quiet_active: assert property (p_quiet_active) else $error("filler while active"); // [R11]

  property p_facch_on;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_burst_pre && i_facch_pending) |=> o_tx_gate;
  endproperty
  a_facch_on: assert property (p_facch_on) else $error("gate off for signalling"); // [R9]

  property p_dummy_on;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_burst_pre && (ctrl[DTXC_CTRL_C0] || ctrl[DTXC_CTRL_FILL])) |=> o_tx_gate;
  endproperty
  a_dummy_on: assert property (p_dummy_on) else $error("gate off for dummy bursts"); // [R9]

  // Gate moves only at a burst decision
  property p_gate_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_burst_pre |=> $stable(o_tx_gate);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate moved mid burst"); // [R20]

  property p_speech_leaves;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (state == DTXC_ST_SPEECH_SIL && dl_speech) |=> (state == DTXC_ST_ACTIVE);
  endproperty
  a_speech_leaves: assert property (p_speech_leaves) else $error("speech kept silent"); // [R7]

  property p_drop_pulse;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_dl_frame_valid |=> !o_tx_frame_drop;
  endproperty
  a_drop_pulse: assert property (p_drop_pulse) else $error("drop without frame"); // [R10]

  property p_ul_valid;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_ul_frame_valid |=> o_ul_frame_valid;
  endproperty
  a_ul_valid: assert property (p_ul_valid) else $error("uplink frame lost"); // [R14]

  property p_ul_speech;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ul_frame_valid && ul_speech && !ul_noise) |=> !o_ul_comfort_noise;
  endproperty
  a_ul_speech: assert property (p_ul_speech) else $error("noise flag on speech"); // [R16]

  // Uplink silence filler marking per codec
  property p_ul_fs1_fill;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ul_frame_valid && ul_speech && ul_silence && !ul_noise && ul_fs1) |=>
      (o_ul_sid_field == DTXC_SID_SILENCE);
  endproperty
  a_ul_fs1_fill: assert property (p_ul_fs1_fill) else $error("filler field wrong"); // [R17]

  property p_ul_fs2_fill;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ul_frame_valid && ul_speech && ul_silence && !ul_noise &&
       (mode == DTXC_MODE_FS2_UNI || mode == DTXC_MODE_FS2_BI)) |=> o_ul_bfi;
  endproperty
  a_ul_fs2_fill: assert property (p_ul_fs2_fill) else $error("filler bfi missing"); // [R18]

  property p_ul_hs_fill;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ul_frame_valid && ul_speech && ul_silence && !ul_noise &&
       mode == DTXC_MODE_HS) |=> o_ul_bfi;
  endproperty
  a_ul_hs_fill: assert property (p_ul_hs_fill) else $error("half rate bfi missing"); // [R19]

endmodule // dtxc_top

// ===== testbench/dtxc_xcdr_model.sv
// Remote transcoder model: drives downlink speech and data frames
module dtxc_xcdr_model (
  input wire logic i_clk,
  output logic o_dl_valid,
  output logic o_dl_is_data,
  output logic [1:0] o_dl_sid,
  output logic [3:0] o_dl_e1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_dl_valid = 1'b0;
    o_dl_is_data = 1'b0;
    o_dl_sid = 2'h0;
    o_dl_e1 = 4'h0;
  end
  // One frame per pulse; lines flip afterwards so stale values never look valid
  task automatic send(input logic d, input logic [1:0] s, input logic [3:0] e);
    @(posedge i_clk);
    o_dl_valid <= 1'b1;
    o_dl_is_data <= d;
    o_dl_sid <= s;
    o_dl_e1 <= e;
    @(posedge i_clk);
    o_dl_valid <= 1'b0;
    o_dl_is_data <= ~d;
    o_dl_sid <= ~s;
    o_dl_e1 <= ~e;
  endtask
endmodule // dtxc_xcdr_model

// ===== testbench/tb_dtxc_top.sv
// Self-checking bench for the discontinuous transmission control block
module tb_dtxc_top
  import dtxc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic burst = 1'b0, sidp = 1'b0, altp = 1'b0, stol = 1'b0, facch = 1'b0;
  logic ulv = 1'b0, ulsp = 1'b0, ulbfi = 1'b0;
  logic [1:0] ulsid = 2'h0, osid, dsid;
  logic [3:0] de1;
  logic ack, gate, drop, fillf, sidf, dind, oulv, ocn, obfi, dlv, dld, bp_d = 1'b0, dl_d = 1'b0;
  logic [31:0] rd_q[$];
  logic [2:0] gt_q[$];
  logic [31:0] rexp;
  logic dr_q[$];
  logic [3:0] ul_q[$];
  int miscompares = 0, tests_run = 0;
  logic [3:0] s, m;
  logic c0, fl, sch, sl;
  always #5 clk = ~clk;
  dtxc_xcdr_model dtxc_xcdr_model_inst (.i_clk(clk), .o_dl_valid(dlv), .o_dl_is_data(dld),
    .o_dl_sid(dsid), .o_dl_e1(de1));
  dtxc_top dtxc_top_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_ack(ack),
    .o_wb_dat(rdat), .i_dl_frame_valid(dlv), .i_dl_frame_is_data(dld), .i_dl_sid_code(dsid),
    .i_dl_e1_bits(de1), .i_burst_pre(burst), .i_sid_position(sidp), .i_alt_sid_position(altp),
    .i_sid_stolen(stol), .i_facch_pending(facch), .o_tx_gate(gate), .o_tx_frame_drop(drop),
    .o_send_fill_frame(fillf), .o_send_sid_frame(sidf),
    .o_downlink_silence_gating_indicator(dind), .i_ul_frame_valid(ulv),
    .i_ul_frame_is_speech(ulsp), .i_ul_sid_code(ulsid), .i_ul_bfi(ulbfi),
    .o_ul_frame_valid(oulv), .o_ul_comfort_noise(ocn), .o_ul_sid_field(osid), .o_ul_bfi(obfi));
  task automatic rep(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e); rep(g, e); endtask
  task automatic chk_bit(input logic g, input logic e); rep({31'h0, g}, {31'h0, e}); endtask
  task automatic chk_ul(input logic [3:0] g, input logic [3:0] e); rep({28'h0, g}, {28'h0, e}); endtask
  // Burst result: gate, descriptor frame, fill frame
  task automatic chk_bst(input logic [2:0] g, input logic [2:0] e);
    rep({29'h0, g}, {29'h0, e});
  endtask
  // Classic cycle: hold everything until ack is sampled, then drop for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) rep(32'h0, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // Apply a channel activation with mode and downlink indicator
  task automatic ld(input logic [3:0] md, input logic ind);
    wb(1'b1, DTXC_REG_CTRL, {23'h0, 1'b1, md, 3'h0, ind});
  endtask
  task automatic bu(input logic [3:0] sv, input logic [2:0] e);
    @(posedge clk);
    burst <= 1'b1;
    {sidp, altp, stol, facch} <= sv;
    gt_q.push_back(e);
    @(posedge clk);
    burst <= 1'b0;
  endtask
  task automatic dl(input logic d, input logic [1:0] sc, input logic [3:0] e, input logic x);
    dr_q.push_back(x);
    dtxc_xcdr_model_inst.send(d, sc, e);
  endtask
  task automatic ul(input logic sp, input logic [1:0] sc, input logic b, input logic [3:0] e);
    @(posedge clk);
    {ulv, ulsp, ulsid, ulbfi} <= {1'b1, sp, sc, b};
    ul_q.push_back(e);
    @(posedge clk);
    ulv <= 1'b0;
  endtask
  // Results are matched against the oldest note as they appear
  always @(posedge clk) begin
    if (bp_d) chk_bst({gate, sidf, fillf}, gt_q.pop_front());
    if (dl_d) chk_bit(drop, dr_q.pop_front());
    if (oulv === 1'b1) chk_ul({ocn, osid, obfi}, ul_q.pop_front());
    if (ack === 1'b1 && we === 1'b0) begin
      rexp = rd_q.pop_front();
      chk_reg(rdat, rexp);
      if (adr == DTXC_REG_STATUS) chk_bit(dind, rexp[3]);
    end
    bp_d <= burst;
    dl_d <= dlv;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    finish_test();
  end
  initial begin
    void'($urandom(25952));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(DTXC_REG_CTRL, DTXC_CTRL_RESET);
    rd(DTXC_REG_SCHED, DTXC_SCHED_RESET);
    wb(1'b1, 8'h0c, $urandom);
    rd(8'h0c, 32'h0);
    ld(4'h1, 1'b0);
    rd(DTXC_REG_STATUS, 32'h10);
    // Every mode: only speech and the listed data rates become active
    for (int i = 0; i < 13; i++) begin
      m = i[3:0];
      ld(m, 1'b1);
      rd(DTXC_REG_STATUS, {27'h0, 1'b1, (m >= 4'h1 && m <= 4'ha), 3'h4});
    end
    ld(DTXC_MODE_FS1_UNI, 1'b1);
    dl(1'b0, DTXC_SID_VALID, 4'h0, 1'b0);
    // Random schedule while silent: gate only for the exception cases
    for (int i = 0; i < 12; i++) begin
      {c0, fl, sch} = 3'($urandom);
      s = 4'($urandom);
      wb(1'b1, DTXC_REG_SCHED, {31'h0, sch});
      wb(1'b1, DTXC_REG_CTRL, {24'h0, 4'h1, fl, c0, 2'h1});
      sl = (s[1] ? s[2] : s[3]) & sch;
      bu(s, {sl | s[0] | c0 | fl, sl, 1'b0});
    end
    wb(1'b1, DTXC_REG_SCHED, 32'h1);
    dl(1'b0, DTXC_SID_SPEECH, 4'h0, 1'b0);
    bu(4'h0, 3'b100);
    ld(DTXC_MODE_NT144_UNI, 1'b1);
    dl(1'b1, 2'($urandom), DTXC_E1_ALL, 1'b1);
    bu(4'h0, 3'b000);
    bu(4'h1, 3'b100);
    bu(4'h6, 3'b101);
    dl(1'b1, 2'h0, 4'h7, 1'b0);
    bu(4'h0, 3'b100);
    ld(DTXC_MODE_NT48_FR, 1'b1);
    dl(1'b1, 2'h0, DTXC_E1_ALL, 1'b0);
    bu(4'h0, 3'b100);
    // Uplink marking per codec, then data passes untouched
    for (int k = 0; k < 3; k++) begin
      m = (k == 0) ? 4'h1 : (k == 1) ? 4'h4 : 4'h5;
      ld(m, 1'b0);
      ul(1'b1, DTXC_SID_VALID, 1'b0, {1'b1, DTXC_SID_VALID, 1'b0});
      ul(1'b1, 2'h0, 1'b0, (k == 0) ? {1'b0, DTXC_SID_SILENCE, 1'b0} : 4'h1);
      ul(1'b1, 2'h0, 1'b0, 4'h0);
      s = 4'($urandom);
      ul(1'b0, s[1:0], s[2], {1'b0, s[1:0], s[2]});
    end
    repeat (5) @(posedge clk);
    // Every note must have met its result
    rep(32'(rd_q.size() + gt_q.size() + dr_q.size() + ul_q.size()), 32'h0);
    finish_test();
  end
endmodule // tb_dtxc_top
